// [rtl/lcd_common_pin_driver_control.sv]
// Functional notes
// RULE_01: Pin is half-supply common only when master enable and its select are both set.
// RULE_02: Select bits three down to zero map to common outputs three to zero.
// RULE_03: Selected common pins are driven regardless of the port direction setting.
// RULE_04: Bias field bits six to five pick one of four ascending current steps.
// RULE_05: Software keeps reserved top bit zero; it resets to zero.
// RULE_06: Commons on two pins of each of two ports; no segment generation.
// RULE_07: The one control register also sets up the half-bias driver.
// RULE_08: A register write takes effect on pins and bias the next cycle; here pins and bias change two edges after the write strobe.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lcd_common_regs.svh"

module lcd_common_pin_driver_control
    import lcd_common_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic [3:0] gpio_out_value_in,
    input  wire logic [3:0] gpio_out_enable_in,
    output logic      [3:0] pin_gpio_value_out,
    output logic      [3:0] pin_gpio_enable_out,
    output logic      [3:0] lcd_common_output_out,
    output logic            half_bias_enable_out,
    output logic      [3:0] bias_step_out,
    output logic      [7:0] bias_current_ua_out
);

    // ****************************************
    // Control register
    // ****************************************
    logic [7:0] lcd_common_drive_control;
    logic       ctrl_hit;
    assign ctrl_hit = (reg_addr_in == `LCD_CTRL_ADDR);

    // Software write; reserved bit stored as written, resets to zero
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            lcd_common_drive_control <= `LCD_CTRL_RESET; // RULE_05
        else if (reg_write_in && ctrl_hit)
            lcd_common_drive_control <= reg_wdata_in; // RULE_08
    end

    // Read data stands one cycle after the read strobe only
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            reg_rdata_out <= `LCD_READ_IDLE;
        else if (reg_read_in && ctrl_hit)
            reg_rdata_out <= lcd_common_drive_control;
        else
            reg_rdata_out <= `LCD_READ_IDLE;
    end

    // ****************************************
    // Pin function
    // ****************************************
    logic       master_en;
    logic [3:0] next_common;
    assign master_en   = lcd_common_drive_control[`LCD_MASTER_BIT];
    // Bit n selects common n
    assign next_common = {4{master_en}} &
                         lcd_common_drive_control[`LCD_SEL_HI:`LCD_SEL_LO]; // RULE_01 RULE_02

    // Common pins override port direction and value; pins 0-1 one port, 2-3 another
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            lcd_common_output_out <= `LCD_PINS_IDLE;
            pin_gpio_value_out    <= `LCD_PINS_IDLE;
            pin_gpio_enable_out   <= `LCD_PINS_IDLE;
        end
        else
        begin
            lcd_common_output_out <= next_common; // RULE_06
            pin_gpio_value_out    <= gpio_out_value_in & ~next_common; // RULE_03
            pin_gpio_enable_out   <= gpio_out_enable_in & ~next_common; // RULE_03
        end
    end

    // ****************************************
    // Bias control
    // ****************************************
    bias_step_t next_step;
    logic [7:0] next_ua;
    logic [1:0] bias_code;
    assign bias_code = lcd_common_drive_control[`LCD_BIAS_HI:`LCD_BIAS_LO];

    // Ascending current steps, lowest code gives lowest current
    always_comb
    begin
        case (bias_code) // RULE_04
            `LCD_BIAS_CODE_0:
            begin
                next_step = BIAS_STEP_0;
                next_ua   = `LCD_BIAS_UA_0;
            end
            `LCD_BIAS_CODE_1:
            begin
                next_step = BIAS_STEP_1;
                next_ua   = `LCD_BIAS_UA_1;
            end
            `LCD_BIAS_CODE_2:
            begin
                next_step = BIAS_STEP_2;
                next_ua   = `LCD_BIAS_UA_2;
            end
            `LCD_BIAS_CODE_3:
            begin
                next_step = BIAS_STEP_3;
                next_ua   = `LCD_BIAS_UA_3;
            end
            default:
            begin
                next_step = BIAS_STEP_0;
                next_ua   = `LCD_BIAS_UA_0;
            end
        endcase
    end

    // Half-bias driver on whenever any common is active
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            bias_step_out        <= BIAS_STEP_0;
            bias_current_ua_out  <= `LCD_BIAS_UA_0;
            half_bias_enable_out <= `LCD_BIAS_OFF;
        end
        else
        begin
            bias_step_out        <= next_step; // RULE_07
            bias_current_ua_out  <= next_ua;
            half_bias_enable_out <= |next_common; // RULE_07
        end
    end

    // ****************************************
    // Checks on pin function
    // ****************************************
    logic [3:0] common_sel;
    assign common_sel = lcd_common_drive_control[`LCD_SEL_HI:`LCD_SEL_LO];

    // Master enable off keeps every pin a general I/O
    a_common_needs_master: assert property ( // RULE_01
        @(posedge clk_sys_in) disable iff (rst_in)
        !master_en |=> (lcd_common_output_out == `LCD_PINS_IDLE))
        else $error("common active without master enable");

    // Commons follow master enable and select one cycle later
    a_common_follows_select: assert property ( // RULE_01
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 (lcd_common_output_out == ($past(master_en) ? $past(common_sel) : `LCD_PINS_IDLE)))
        else $error("common output mismatch");

    // Select bit zero drives common zero
    a_select_pin_zero: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (rst_in)
        (master_en && common_sel[`LCD_SEL_LO]) |=> lcd_common_output_out[`LCD_SEL_LO])
        else $error("select bit zero not mapped");

    // Select bit one drives common one
    a_select_pin_one: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (rst_in)
        (master_en && common_sel[`LCD_SEL_ONE]) |=> lcd_common_output_out[`LCD_SEL_ONE])
        else $error("select bit one not mapped");

    // Select bit two drives common two
    a_select_pin_two: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (rst_in)
        (master_en && common_sel[`LCD_SEL_TWO]) |=> lcd_common_output_out[`LCD_SEL_TWO])
        else $error("select bit two not mapped");

    // Select bit three drives common three
    a_select_pin_three: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (rst_in)
        (master_en && common_sel[`LCD_SEL_HI]) |=> lcd_common_output_out[`LCD_SEL_HI])
        else $error("select bit three not mapped");

    // A cleared select never yields a common
    a_select_clear_gpio: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 ((lcd_common_output_out & ~$past(common_sel)) == `LCD_PINS_IDLE))
        else $error("unselected pin became common");

    // Port direction never drives a common pin
    a_direction_override: assert property ( // RULE_03
        @(posedge clk_sys_in) disable iff (rst_in)
        (lcd_common_output_out & pin_gpio_enable_out) == `LCD_PINS_IDLE)
        else $error("gpio drives a common pin");

    // Port direction passes through on general I/O pins
    a_gpio_enable_pass: assert property ( // RULE_03
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 (pin_gpio_enable_out == ($past(gpio_out_enable_in) & ~lcd_common_output_out)))
        else $error("gpio direction not passed");

    // Port value passes through on general I/O pins
    a_gpio_value_pass: assert property ( // RULE_03
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 (pin_gpio_value_out == ($past(gpio_out_value_in) & ~lcd_common_output_out)))
        else $error("gpio value not passed");

    // A common pin carries no software level
    a_common_value_quiet: assert property ( // RULE_06
        @(posedge clk_sys_in) disable iff (rst_in)
        (lcd_common_output_out & pin_gpio_value_out) == `LCD_PINS_IDLE)
        else $error("software level on a common pin");

    // With no commons all four pins stay software lines
    a_segments_by_software: assert property ( // RULE_06
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 ((lcd_common_output_out == `LCD_PINS_IDLE) ->
            (pin_gpio_value_out == $past(gpio_out_value_in))))
        else $error("segment line altered by block");

    // ****************************************
    // Checks on bias control
    // ****************************************
    // Lowest code gives the lowest current
    a_bias_decode_zero: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (rst_in)
        (bias_code == `LCD_BIAS_CODE_0) |=> (bias_current_ua_out == `LCD_BIAS_UA_0))
        else $error("bias step zero wrong");

    // Second code gives the second current
    a_bias_decode_one: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (rst_in)
        (bias_code == `LCD_BIAS_CODE_1) |=> (bias_current_ua_out == `LCD_BIAS_UA_1))
        else $error("bias step one wrong");

    // Third code gives the third current
    a_bias_decode_two: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (rst_in)
        (bias_code == `LCD_BIAS_CODE_2) |=> (bias_current_ua_out == `LCD_BIAS_UA_2))
        else $error("bias step two wrong");

    // Top code gives the highest current and step
    a_bias_decode_top: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (rst_in)
        (bias_code == `LCD_BIAS_CODE_3) |=>
        (bias_current_ua_out == `LCD_BIAS_UA_3 && bias_step_out == BIAS_STEP_3))
        else $error("bias step wrong");

    // Exactly one bias step is active
    a_step_onehot: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (rst_in)
        $onehot(bias_step_out))
        else $error("bias step not one-hot");

    // Half-bias driver matches the active commons
    a_half_bias_on: assert property ( // RULE_07
        @(posedge clk_sys_in) disable iff (rst_in)
        half_bias_enable_out == (lcd_common_output_out != `LCD_PINS_IDLE))
        else $error("half bias inconsistent");

    // Half-bias driver follows the register one cycle later
    a_half_bias_follows: assert property ( // RULE_07
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 (half_bias_enable_out == (|$past(next_common))))
        else $error("half bias late or early");

    // ****************************************
    // Checks on register access
    // ****************************************
    // Reset clears the whole register, reserved bit too
    a_reserved_reset: assert property ( // RULE_05
        @(posedge clk_sys_in)
        rst_in |=> (lcd_common_drive_control == `LCD_CTRL_RESET))
        else $error("control not reset");

    // Reset leaves pins as general I/O and the driver off
    a_reset_outputs: assert property ( // RULE_05
        @(posedge clk_sys_in)
        rst_in |=> (lcd_common_output_out == `LCD_PINS_IDLE &&
            half_bias_enable_out == `LCD_BIAS_OFF))
        else $error("outputs not reset");

    // A write lands in the register at the next edge
    a_write_next_cycle: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_write_in && ctrl_hit) |=> (lcd_common_drive_control == $past(reg_wdata_in)))
        else $error("write not stored");

    // A write reaches the pins two edges after its strobe
    a_write_two_cycles: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_write_in && ctrl_hit && reg_wdata_in[`LCD_MASTER_BIT] &&
            reg_wdata_in[`LCD_SEL_LO]) |=> ##1 lcd_common_output_out[`LCD_SEL_LO])
        else $error("write not applied");

    // Writes to other addresses are ignored
    a_write_other_addr: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_write_in && !ctrl_hit) |=> $stable(lcd_common_drive_control))
        else $error("stray write changed register");

    // Read data shows the register in the cycle after the strobe
    a_read_back: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_read_in && ctrl_hit) |=> (reg_rdata_out == $past(lcd_common_drive_control)))
        else $error("read data wrong");

    // Read data idles at zero otherwise
    a_read_idle: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (rst_in)
        !(reg_read_in && ctrl_hit) |=> (reg_rdata_out == `LCD_READ_IDLE))
        else $error("read data not idle");

endmodule : lcd_common_pin_driver_control

// [rtl/lcd_common_pkg.sv]
package lcd_common_pkg;
    typedef enum logic [3:0] {
        BIAS_STEP_0 = 4'b0001,
        BIAS_STEP_1 = 4'b0010,
        BIAS_STEP_2 = 4'b0100,
        BIAS_STEP_3 = 4'b1000
    } bias_step_t;
endpackage : lcd_common_pkg

// [rtl/lcd_common_regs.svh]
`ifndef LCD_COMMON_REGS_SVH
`define LCD_COMMON_REGS_SVH

// Register address and layout
`define LCD_CTRL_ADDR      4'h0
`define LCD_CTRL_RESET     8'h00
`define LCD_RSVD_BIT       7
`define LCD_BIAS_HI        6
`define LCD_BIAS_LO        5
`define LCD_MASTER_BIT     4
`define LCD_SEL_HI         3
`define LCD_SEL_LO         0
`define LCD_SEL_ONE        1
`define LCD_SEL_TWO        2
`define LCD_PINS_IDLE      4'h0
`define LCD_BIAS_OFF       1'b0
`define LCD_BIAS_CODE_0    2'h0
`define LCD_BIAS_CODE_1    2'h1
`define LCD_BIAS_CODE_2    2'h2
`define LCD_BIAS_CODE_3    2'h3
`define LCD_READ_IDLE      8'h00
// Bias current figures in microamps
`define LCD_BIAS_UA_0      8'h19
`define LCD_BIAS_UA_1      8'h32
`define LCD_BIAS_UA_2      8'h64
`define LCD_BIAS_UA_3      8'hC8

`endif

// [tb/lcd_panel_model.sv]
`timescale 1ns/1ps
// Panel side: a driven common electrode must see the half-bias level
module lcd_panel_model
(
    input  wire logic [3:0] lcd_common_output_in,
    input  wire logic       half_bias_enable_in,
    output logic            panel_fault_out
);
    // Fault when commons and the half-bias supply disagree
    assign panel_fault_out = (|lcd_common_output_in) != half_bias_enable_in;
endmodule : lcd_panel_model

// [tb/tb_lcd_common_pin_driver_control.sv]
`timescale 1ns/1ps
module tb_lcd_common_pin_driver_control;
    logic        clk_sys_in, rst_in, wr, rd, bias, fault;
    logic        rd_seen = 1'b0;
    logic [3:0]  addr, gv, ge, com, gval, gen, step;
    logic [7:0]  wdata, rdata, ua, ctl;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    logic [7:0]  dir[5] = '{8'h0F, 8'h1F, 8'h35, 8'h5A, 8'h7C};
    logic [31:0] seed;
    int          n_mismatch = 0, n_compared = 0, cycles = 0;

    lcd_common_pin_driver_control lcd_common_pin_driver_control_inst (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
        .reg_read_in(rd), .reg_rdata_out(rdata), .gpio_out_value_in(gv),
        .gpio_out_enable_in(ge), .pin_gpio_value_out(gval), .pin_gpio_enable_out(gen),
        .lcd_common_output_out(com), .half_bias_enable_out(bias), .bias_step_out(step),
        .bias_current_ua_out(ua));
    lcd_panel_model lcd_panel_model_inst (.lcd_common_output_in(com),
        .half_bias_enable_in(bias), .panel_fault_out(fault));

    // Random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic complete_run;
        if (n_compared > 0 && n_mismatch == 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Write, then read back at once; note what pins and read data must show
    task automatic op(input logic [3:0] a, input logic [7:0] d);
        logic [3:0] c;
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        gv <= seed[11:8];
        ge <= seed[15:12];
        @(posedge clk_sys_in);
        wr <= 1'b0;
        rd <= 1'b1;
        if (a == 4'h0) ctl = d;
        c = ctl[4] ? ctl[3:0] : 4'h0;
        exp_q.push_back({(a == 4'h0) ? ctl : 8'h00, c, |c, 4'h1 << ctl[6:5],
            8'h19 << ctl[6:5], seed[11:8] & ~c, seed[15:12] & ~c, 1'b0});
        seed = xs(seed);
        @(posedge clk_sys_in);
        rd <= 1'b0;
    endtask : op

    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // Hang guard
    always @(posedge clk_sys_in)
    begin
        cycles++;
        rd_seen <= rd;
        if (cycles > 1000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // Compare the oldest note once read data and pins have settled
    always @(negedge clk_sys_in)
        if (rd_seen)
        begin
            e = exp_q.pop_front();
            n_compared++;
            if (e !== {rdata, com, bias, step, ua, gval, gen, fault})
            begin
                n_mismatch++;
                $display("unexpected at %0t exp %h got %h", $time,
                    e, {rdata, com, bias, step, ua, gval, gen, fault});
            end
        end

    initial
    begin
        rst_in = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        gv = 4'h0;
        ge = 4'h0;
        seed = 32'h60;
        ctl = 8'h00;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        op(4'h1, 8'h3F);
        foreach (dir[i]) op(4'h0, dir[i]);
        repeat (40) op({3'h0, seed[16] & seed[17]}, {1'b0, seed[30:24]});
        op(4'h0, 8'h00);
        repeat (3) @(posedge clk_sys_in);
        complete_run();
    end
endmodule : tb_lcd_common_pin_driver_control
